// ===== src/smr_pkg.sv
// Purpose: Shared constants and types for the serial mux redriver control block.
// Assumes: One 50 MHz clock; control pins pass a two-flop synchroniser, strap pins are registered once.
// Notes:   Analog conditioning is represented only by decoded control levels.
// How it works
// - Enable low keeps standby: redrivers off, receiver detection idle.
// - Channel one output selector low picks output A, high picks output B.
// - Channel two input selector low picks input A, high picks input B.
// - Deemphasis code 00/01/10/11 gives 0 low swing, 0, 3.5 dB, 6 dB.
// - Deemphasis code 00 puts the output in low-swing mode.
// - Equalization code 0x gives 0 dB, 10 gives 3.5 dB, 11 gives 6 dB.
// - Channel one: one input eq, two output deemphasis; channel two the reverse.
// - Detection starts on enable rising and at power-up with enable high.
// - With enable high, trigger or selector edges restart detection.
// - During detection the device stays in standby with outputs squelched.
// - Detection retries without limit on both channels until a receiver is found on either one.
// - After one channel finds a receiver, the other gets at most 2^16 more tries.
// - A found receiver enables that channel's driver and idle detection.
// - Input below idle threshold squelches the corresponding output.
// - Input above idle threshold turns the output on and redrives.
// - Unconnected selectors read low, giving the A path.
package smr_pkg;
    localparam int unsigned SYNC_STAGES   = 2;
    localparam int unsigned EXTRA_TRIES   = 65536;
    localparam int unsigned TRY_CNT_W     = 17;
    localparam int unsigned ATTEMPT_CYC   = 16;
    localparam logic [1:0]  DE_LOW_SWING  = 2'h0;

    typedef enum logic [1:0] {
        SMR_DE_0DB_LOW,
        SMR_DE_0DB_FULL,
        SMR_DE_3P5DB,
        SMR_DE_6DB
    } smr_deemph_t;

    typedef enum logic [1:0] {
        SMR_EQ_0DB,
        SMR_EQ_3P5DB,
        SMR_EQ_6DB
    } smr_eq_t;

    function automatic smr_deemph_t smr_decode_deemph(input logic [1:0] code);
        smr_deemph_t r;
        unique case (code)
            2'h0: r = SMR_DE_0DB_LOW;
            2'h1: r = SMR_DE_0DB_FULL;
            2'h2: r = SMR_DE_3P5DB;
            default: r = SMR_DE_6DB;
        endcase
        return r;
    endfunction

    function automatic smr_eq_t smr_decode_eq(input logic [1:0] code);
        smr_eq_t r;
        if (!code[1]) begin
            r = SMR_EQ_0DB;
        end else if (!code[0]) begin
            r = SMR_EQ_3P5DB;
        end else begin
            r = SMR_EQ_6DB;
        end
        return r;
    endfunction
endpackage

// ===== src/smr_sync.sv
// Purpose: Multi-bit two-flop synchroniser for the enable, trigger and selector control pins.
// Assumes: Each bit is an independent level.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module smr_sync
    import smr_pkg::*;
#(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff   <= '0;
            stable_ff <= '0;
        end else begin
            meta_ff   <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule
`default_nettype wire

// ===== src/smr_ctrl.sv
// Purpose: Standby, path select, strap decode, receiver detection and squelch control.
// Assumes: Analog front ends report receiver presence and idle state as levels.
// Notes:   Each detection attempt lasts ATTEMPT_CYC cycles; rx_present is sampled at its end.
`timescale 1ns/1ps
`default_nettype none
module smr_ctrl
    import smr_pkg::*;
#(
    parameter int unsigned ATTEMPT_CYCLES = ATTEMPT_CYC,
    parameter int unsigned EXTRA_LIMIT    = EXTRA_TRIES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        enable,
    input  wire logic        detect_trigger,
    input  wire logic        ch1_output_path_pick,
    input  wire logic        ch2_input_path_pick,
    input  wire logic        ch1_out_a_deemph_msb,
    input  wire logic        ch1_out_a_deemph_lsb,
    input  wire logic        ch1_out_b_deemph_msb,
    input  wire logic        ch1_out_b_deemph_lsb,
    input  wire logic        ch2_out_deemph_msb,
    input  wire logic        ch2_out_deemph_lsb,
    input  wire logic        ch1_in_eq_msb,
    input  wire logic        ch1_in_eq_lsb,
    input  wire logic        ch2_in_a_eq_msb,
    input  wire logic        ch2_in_a_eq_lsb,
    input  wire logic        ch2_in_b_eq_msb,
    input  wire logic        ch2_in_b_eq_lsb,
    input  wire logic [1:0]  rx_present,
    input  wire logic [1:0]  input_idle,
    output logic             standby,
    output logic             detect_busy,
    output logic [1:0]       rx_found,
    output logic [1:0]       driver_on,
    output logic [1:0]       idle_det_on,
    output logic [1:0]       out_active,
    output logic             ch1_route_b,
    output logic             ch2_route_b,
    output logic [1:0]       ch1_out_a_deemph,
    output logic [1:0]       ch1_out_b_deemph,
    output logic [1:0]       ch2_out_deemph,
    output logic             ch1_out_a_low_swing,
    output logic             ch1_out_b_low_swing,
    output logic             ch2_out_low_swing,
    output logic [1:0]       ch1_in_eq,
    output logic [1:0]       ch2_in_a_eq,
    output logic [1:0]       ch2_in_b_eq
);
    typedef enum logic [1:0] {SMR_OFF, SMR_DETECT, SMR_RUN} smr_state_t;

    logic [3:0]           sync_q;
    logic                 en_s, trig_s, ch1_output_path_pick_s, ch2_input_path_pick_s;
    logic                 en_d_ff, trig_d_ff, ch1_output_path_pick_d_ff, ch2_input_path_pick_d_ff;
    logic                 edge_restart;
    logic                 en_rise;
    smr_state_t           state_ff;
    logic [1:0]           found_ff;
    logic [15:0]          slot_cnt_ff;
    logic [TRY_CNT_W-1:0] extra_cnt_ff;
    logic                 slot_end;
    logic [1:0]           nxt_found;

    smr_sync #(.WIDTH(4)) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({enable, detect_trigger, ch1_output_path_pick, ch2_input_path_pick}),
        .sync_out (sync_q)
    );
    assign {en_s, trig_s, ch1_output_path_pick_s, ch2_input_path_pick_s} = sync_q;

    // Delayed copies start at zero so enable already high at power-up reads as a rise.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_d_ff   <= 1'b0;
            trig_d_ff <= 1'b0;
            ch1_output_path_pick_d_ff <= 1'b0;
            ch2_input_path_pick_d_ff <= 1'b0;
        end else begin
            en_d_ff   <= en_s;
            trig_d_ff <= trig_s;
            ch1_output_path_pick_d_ff <= ch1_output_path_pick_s;
            ch2_input_path_pick_d_ff <= ch2_input_path_pick_s;
        end
    end

    assign en_rise      = en_s && !en_d_ff;
    assign edge_restart = en_s && ((trig_s ^ trig_d_ff) || (ch1_output_path_pick_s ^ ch1_output_path_pick_d_ff)
                                   || (ch2_input_path_pick_s ^ ch2_input_path_pick_d_ff));
    assign slot_end     = (slot_cnt_ff == 16'(ATTEMPT_CYCLES - 1));

    always_comb begin
        nxt_found = found_ff;
        if (slot_end) begin
            nxt_found = found_ff | rx_present;
        end
    end

    // The extra-try limit only applies once a channel was found before this attempt,
    // so a first find with a tiny limit never ends detection with zero extra tries.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= SMR_OFF;
        end else if (!en_s) begin
            state_ff <= SMR_OFF;
        end else if (en_rise || edge_restart) begin
            state_ff <= SMR_DETECT;
        end else if (state_ff == SMR_DETECT && slot_end
                     && (nxt_found == 2'h3
                         || (found_ff != 2'h0
                             && extra_cnt_ff == TRY_CNT_W'(EXTRA_LIMIT - 1)))) begin
            state_ff <= SMR_RUN;
        end
    end

    // Found flags clear only on a restart or while enable is low, so a channel once seen is not probed again.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            found_ff     <= 2'h0;
            slot_cnt_ff  <= 16'h0;
            extra_cnt_ff <= '0;
        end else if (state_ff != SMR_DETECT || en_rise || edge_restart || !en_s) begin
            if (!en_s || en_rise || edge_restart) begin
                found_ff <= 2'h0;
            end
            slot_cnt_ff  <= 16'h0;
            extra_cnt_ff <= '0;
        end else begin
            slot_cnt_ff <= slot_end ? 16'h0 : slot_cnt_ff + 16'h1;
            if (slot_end) begin
                found_ff <= nxt_found;
                if (found_ff != 2'h0) begin
                    extra_cnt_ff <= extra_cnt_ff + TRY_CNT_W'(1);
                end
            end
        end
    end

    assign standby     = (state_ff != SMR_RUN);
    assign detect_busy = (state_ff == SMR_DETECT);
    assign rx_found    = found_ff;
    assign driver_on   = (state_ff == SMR_RUN) ? found_ff : 2'h0;
    assign idle_det_on = driver_on;
    assign out_active  = driver_on & ~input_idle;
    assign ch1_route_b = ch1_output_path_pick_s;
    assign ch2_route_b = ch2_input_path_pick_s;

    // Straps are decoded continuously; they only matter while the drivers are on.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch1_out_a_deemph <= 2'h0;
            ch1_out_b_deemph <= 2'h0;
            ch2_out_deemph   <= 2'h0;
            ch1_in_eq        <= 2'h0;
            ch2_in_a_eq      <= 2'h0;
            ch2_in_b_eq      <= 2'h0;
        end else begin
            ch1_out_a_deemph <= smr_decode_deemph({ch1_out_a_deemph_msb,
                                                   ch1_out_a_deemph_lsb});
            ch1_out_b_deemph <= smr_decode_deemph({ch1_out_b_deemph_msb,
                                                   ch1_out_b_deemph_lsb});
            ch2_out_deemph   <= smr_decode_deemph({ch2_out_deemph_msb,
                                                   ch2_out_deemph_lsb});
            ch1_in_eq   <= smr_decode_eq({ch1_in_eq_msb, ch1_in_eq_lsb});
            ch2_in_a_eq <= smr_decode_eq({ch2_in_a_eq_msb, ch2_in_a_eq_lsb});
            ch2_in_b_eq <= smr_decode_eq({ch2_in_b_eq_msb, ch2_in_b_eq_lsb});
        end
    end

    assign ch1_out_a_low_swing = (ch1_out_a_deemph == DE_LOW_SWING);
    assign ch1_out_b_low_swing = (ch1_out_b_deemph == DE_LOW_SWING);
    assign ch2_out_low_swing   = (ch2_out_deemph == DE_LOW_SWING);

    // Checks read the synchronised pins, so they see the same view as the logic.
    // Route and strap checks look back at the raw pins to catch a wrong pipeline depth.
    chk_off_standby: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !en_s |=> standby && driver_on == 2'h0)
        else $error("standby not held");
    chk_drop_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !en_s |=> rx_found == 2'h0)
        else $error("found flags kept in standby");
    chk_detect_squelch: assert property (@(posedge sys_clk) disable iff (!reset_n)
        detect_busy |-> standby && out_active == 2'h0)
        else $error("not squelched");
    chk_restart_edge: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (en_s && $changed(trig_s)) |=> detect_busy)
        else $error("no restart");
    chk_sel_restart: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (en_s && ($changed(ch1_output_path_pick_s) || $changed(ch2_input_path_pick_s))) |=> detect_busy)
        else $error("no restart on selector");
    chk_enable_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(en_s) |=> detect_busy)
        else $error("no detect on enable");
    chk_retry_no_rx: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (detect_busy && en_s && found_ff == 2'h0 && rx_present == 2'h0) |=> detect_busy)
        else $error("detection gave up");
    chk_extra_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
        detect_busy |-> extra_cnt_ff < TRY_CNT_W'(EXTRA_LIMIT))
        else $error("too many extra tries");
    chk_idle_squelch: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (input_idle[0] || !driver_on[0]) |-> !out_active[0])
        else $error("idle out");
    chk_redrive_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (driver_on[1] && !input_idle[1]) |-> out_active[1])
        else $error("not on");
    chk_route_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ch1_route_b == $past(ch1_output_path_pick, 2)
        && ch2_route_b == $past(ch2_input_path_pick, 2))
        else $error("route");
    chk_run_needs_rx: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_ff == SMR_RUN) |-> found_ff != 2'h0)
        else $error("run without rx");
    chk_found_drives: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (detect_busy && en_s && !edge_restart && slot_end && rx_present == 2'h3)
        |=> driver_on == 2'h3)
        else $error("found receiver not driven");
    chk_low_swing: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past({ch2_out_deemph_msb, ch2_out_deemph_lsb}) == 2'h0 |-> ch2_out_low_swing)
        else $error("low swing");
    chk_deemph_decode: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past({ch1_out_a_deemph_msb, ch1_out_a_deemph_lsb}) == 2'h3
        |-> ch1_out_a_deemph == SMR_DE_6DB)
        else $error("deemphasis decode");
    chk_eq_decode: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past({ch1_in_eq_msb, ch1_in_eq_lsb}) == 2'h2 |-> ch1_in_eq == SMR_EQ_3P5DB)
        else $error("eq decode");
endmodule
`default_nettype wire

// ===== tb/smr_link_partner.sv
// Purpose: Link partner model giving receiver presence and idle state per channel.
// Assumes: The bench says which channels have a receiver and which inputs are quiet.
// Notes:   Outputs move just after a clock edge, like a real probe result.
`timescale 1ns/1ps
`default_nettype none
module smr_link_partner (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] attach,
    input  wire logic [1:0] quiet,
    output logic      [1:0] rx_present,
    output logic      [1:0] input_idle
);
    // An absent partner sends nothing, so its input is idle as well.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_present <= 2'h0;
            input_idle <= 2'h3;
        end else begin
            rx_present <= attach;
            input_idle <= quiet | ~attach;
        end
    end
endmodule
`default_nettype wire

// ===== tb/smr_ctrl_tb_top.sv
// Purpose: Self-checking bench for the redriver control block.
// Assumes: Short attempt and extra-try counts keep detection runs brief.
// Notes:   All twelve straps travel in one vector split across the pins.
`timescale 1ns/1ps
`default_nettype none
module smr_ctrl_tb_top;
    import smr_pkg::*;
    localparam int ATT = 4;
    localparam int EXTRA = 4;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        enable = 1'b0;
    logic        trig = 1'b0;
    logic        pick1 = 1'b0;
    logic        pick2 = 1'b0;
    logic [11:0] strap = 12'h000;
    logic [1:0]  attach = 2'h0;
    logic [1:0]  quiet = 2'h0;
    logic [1:0]  rx_present, input_idle, rx_found, driver_on, idle_det_on, out_active;
    logic [1:0]  de_a, de_b, de_2, eq_1, eq_a, eq_b;
    logic        standby, detect_busy, route1, route2, ls_a, ls_b, ls_2;
    int          err_total = 0;
    int          n_compared = 0;
    int          cycles = 0;

    smr_link_partner PARTNER (.sys_clk(sys_clk), .reset_n(reset_n), .attach(attach),
        .quiet(quiet), .rx_present(rx_present), .input_idle(input_idle));
    smr_ctrl #(.ATTEMPT_CYCLES(ATT), .EXTRA_LIMIT(EXTRA)) DUT (
        .sys_clk(sys_clk), .reset_n(reset_n), .enable(enable), .detect_trigger(trig),
        .ch1_output_path_pick(pick1), .ch2_input_path_pick(pick2),
        .ch1_out_a_deemph_msb(strap[11]), .ch1_out_a_deemph_lsb(strap[10]),
        .ch1_out_b_deemph_msb(strap[9]), .ch1_out_b_deemph_lsb(strap[8]),
        .ch2_out_deemph_msb(strap[7]), .ch2_out_deemph_lsb(strap[6]),
        .ch1_in_eq_msb(strap[5]), .ch1_in_eq_lsb(strap[4]),
        .ch2_in_a_eq_msb(strap[3]), .ch2_in_a_eq_lsb(strap[2]),
        .ch2_in_b_eq_msb(strap[1]), .ch2_in_b_eq_lsb(strap[0]),
        .rx_present(rx_present), .input_idle(input_idle), .standby(standby),
        .detect_busy(detect_busy), .rx_found(rx_found), .driver_on(driver_on),
        .idle_det_on(idle_det_on), .out_active(out_active), .ch1_route_b(route1),
        .ch2_route_b(route2), .ch1_out_a_deemph(de_a), .ch1_out_b_deemph(de_b),
        .ch2_out_deemph(de_2), .ch1_out_a_low_swing(ls_a), .ch1_out_b_low_swing(ls_b),
        .ch2_out_low_swing(ls_2), .ch1_in_eq(eq_1), .ch2_in_a_eq(eq_a), .ch2_in_b_eq(eq_b));

    always #10 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Bounded wait, so a stuck detector shows up as a mismatch, not a hang.
    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (detect_busy !== lvl && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
    endtask

    function automatic logic [1:0] eqx(input logic [1:0] c);
        return c[1] ? (c[0] ? 2'h2 : 2'h1) : 2'h0;
    endfunction

    task automatic t_standby;
        repeat (20) @(negedge sys_clk);
        check("standby", {1'b0, standby}, 2'h1);
        check("busy", {1'b0, detect_busy}, 2'h0);
        check("driver_on", driver_on, 2'h0);
    endtask

    task automatic t_straps;
        logic [1:0] a, b, d;
        for (int i = 0; i < 4; i++) begin
            a = 2'(i);
            b = a + 2'h1;
            d = a + 2'h2;
            strap = {a, b, d, a, b, d};
            repeat (3) @(negedge sys_clk);
            check("de_a", de_a, a);
            check("de_b", de_b, b);
            check("de_2", de_2, d);
            check("ls_a", {1'b0, ls_a}, {1'b0, a == 2'h0});
            check("ls_b", {1'b0, ls_b}, {1'b0, b == 2'h0});
            check("ls_2", {1'b0, ls_2}, {1'b0, d == 2'h0});
            check("eq_1", eq_1, eqx(a));
            check("eq_a", eq_a, eqx(b));
            check("eq_b", eq_b, eqx(d));
        end
    endtask

    task automatic t_enable_rise;
        attach = 2'h3;
        enable = 1'b1;
        wait_busy(1'b1, 8);
        check("busy", {1'b0, detect_busy}, 2'h1);
        check("standby", {1'b0, standby}, 2'h1);
        check("driver_on", driver_on, 2'h0);
        wait_busy(1'b0, 20 * ATT);
        check("standby", {1'b0, standby}, 2'h0);
        check("driver_on", driver_on, 2'h3);
        check("idle_det_on", idle_det_on, 2'h3);
        check("rx_found", rx_found, 2'h3);
        quiet = 2'h1;
        repeat (2) @(negedge sys_clk);
        check("out_active", out_active, 2'h2);
        quiet = 2'h0;
    endtask

    task automatic t_restart;
        check("route", {route2, route1}, 2'h0);
        for (int k = 0; k < 3; k++) begin
            if (k == 0) trig = ~trig;
            if (k == 1) pick1 = 1'b1;
            if (k == 2) pick2 = 1'b1;
            wait_busy(1'b1, 8);
            check("busy", {1'b0, detect_busy}, 2'h1);
            wait_busy(1'b0, 20 * ATT);
        end
        check("route", {route2, route1}, 2'h3);
    endtask

    task automatic t_one_side;
        attach = 2'h0;
        trig = ~trig;
        wait_busy(1'b1, 8);
        repeat (30 * ATT) @(negedge sys_clk);
        check("busy", {1'b0, detect_busy}, 2'h1);
        check("rx_found", rx_found, 2'h0);
        attach = 2'h1;
        wait_busy(1'b0, (EXTRA + 2) * ATT + 2);
        check("busy", {1'b0, detect_busy}, 2'h0);
        check("driver_on", driver_on, 2'h1);
        check("rx_found", rx_found, 2'h1);
        enable = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("standby", {1'b0, standby}, 2'h1);
        check("driver_on", driver_on, 2'h0);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
        t_standby();
        t_straps();
        t_enable_rise();
        t_restart();
        t_one_side();
        finish_test();
    end
endmodule
`default_nettype wire
